// ==== inc/core_stack_pkg.sv ====
// Operation
// - return stack holds eight 13-bit entries, separate from program and data memory
// - stack pointer has no software read or write path
// - push current pc on subroutine call or interrupt vectoring
// - pop top entry into pc on return, return-with-literal, return-from-interrupt
// - pushes and pops leave pc_high_latch unchanged
// - stack is circular; ninth push overwrites first entry
// - no overflow or underflow status flags exist
// - indirect_data_port access redirects to location chosen by indirect_pointer
// - read through pointer that selects indirect_data_port returns 00h
// - write through pointer that selects indirect_data_port stores nothing
// - indirect address is indirect_bank_select above the 8-bit indirect_pointer
// - 13-bit pc: low byte register, upper bits from pc_high_latch
package core_stack_pkg;
   localparam int PC_W = 13;
   localparam int STACK_DEPTH = 8;
   localparam int DADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int PTR_W = 3;
   localparam int PCH_W = PC_W - DATA_W;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
   localparam logic [PTR_W-1:0] PTR_STEP = 3'h1;
   localparam logic [DATA_W-1:0] INDIRECT_PORT_ADDR = 8'h00;
   localparam logic [DATA_W-1:0] INDIRECT_NULL_READ = 8'h00;
   localparam logic [PCH_W-1:0] PCH_RESET = 5'h00;
   localparam int STATUS_BANK_BIT = 7;

   typedef enum logic [1:0] {
      PC_HOLD,
      PC_INC,
      PC_LOAD
   } pc_op_t;

   // sequencer command for one instruction cycle
   typedef struct packed {
      logic do_push;
      logic do_pop;
      logic load_low;
      pc_op_t pc_op;
      logic [PC_W-1:0] load_value;
      logic [DATA_W-1:0] low_value;
   } seq_cmd_t;

   // data access request from the sequencer
   typedef struct packed {
      logic valid;
      logic write;
      logic [DATA_W-1:0] file_addr;
      logic [DATA_W-1:0] wdata;
   } data_req_t;

   // resolved access towards data memory
   typedef struct packed {
      logic valid;
      logic write;
      logic [DADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } mem_req_t;
endpackage : core_stack_pkg

// ==== design/indirect_addr.sv ====
`timescale 1ns/10ps
`default_nettype none
module indirect_addr (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // request from sequencer
   input core_stack_pkg::data_req_t req,
   input wire logic [core_stack_pkg::DATA_W-1:0] indirect_pointer,
   input wire logic indirect_bank_select,
   input wire logic [core_stack_pkg::DATA_W-1:0] bank_direct,
   // resolved access
   output core_stack_pkg::mem_req_t mem,
   output logic null_read
);
   import core_stack_pkg::*;

   function automatic logic is_port(input logic [DATA_W-1:0] a);
      return a == INDIRECT_PORT_ADDR;
   endfunction : is_port

   logic indirect;
   logic self_ref;
   assign indirect = is_port(req.file_addr);
   assign self_ref = indirect && is_port(indirect_pointer);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mem <= '0;
         null_read <= 1'b0;
      end else begin
         mem.valid <= req.valid && !self_ref;
         mem.write <= req.write;
         mem.wdata <= req.wdata;
         if (indirect) begin
            mem.addr <= {indirect_bank_select, indirect_pointer};
         end else begin
            mem.addr <= {bank_direct[0], req.file_addr};
         end
         null_read <= req.valid && !req.write && self_ref;
      end
   end

   a_self_write_dropped: assert property (@(posedge sys_clk) disable iff (reset)
      req.valid && req.write && self_ref |=> !mem.valid)
      else $error("self-referencing indirect write reached memory");
   a_indirect_addr_form: assert property (@(posedge sys_clk) disable iff (reset)
      req.valid && indirect && !self_ref |=> mem.addr == {$past(indirect_bank_select), $past(indirect_pointer)})
      else $error("indirect address formed wrongly");
   c_indirect_self: cover property (@(posedge sys_clk) req.valid && self_ref);
endmodule : indirect_addr
`default_nettype wire

// ==== design/core_return_stack.sv ====
`timescale 1ns/10ps
`default_nettype none
module core_return_stack #(
   parameter int DEPTH = core_stack_pkg::STACK_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // sequencer control
   input core_stack_pkg::seq_cmd_t cmd,
   input wire logic [core_stack_pkg::PCH_W-1:0] pc_high_latch_in,
   input wire logic pc_high_latch_we,
   // data path
   input core_stack_pkg::data_req_t req,
   input wire logic [core_stack_pkg::DATA_W-1:0] indirect_pointer,
   input wire logic [core_stack_pkg::DATA_W-1:0] status_reg,
   input wire logic [core_stack_pkg::DATA_W-1:0] mem_rdata,
   // outputs
   output logic [core_stack_pkg::PC_W-1:0] pc,
   output logic [core_stack_pkg::PCH_W-1:0] pc_high_latch,
   output core_stack_pkg::mem_req_t mem,
   output logic [core_stack_pkg::DATA_W-1:0] read_data
);
   import core_stack_pkg::*;

   // --------------------------------------------------------------
   // return stack storage, separate from all memory spaces
   // --------------------------------------------------------------
   logic [PC_W-1:0] stack_mem [DEPTH];
   logic [PTR_W-1:0] sp;
   logic [PC_W-1:0] next_pc;
   logic null_read;
   logic [PTR_W-1:0] top;

   assign top = sp - PTR_STEP;

   // wraps silently, no flags anywhere
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sp <= PTR_RESET;
      end else if (cmd.do_push) begin
         sp <= sp + PTR_STEP;
      end else if (cmd.do_pop) begin
         sp <= sp - PTR_STEP;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (cmd.do_push && !reset) begin
         stack_mem[sp] <= pc;
      end
   end

   // --------------------------------------------------------------
   // program counter
   // --------------------------------------------------------------
   always_comb begin
      next_pc = pc;
      if (cmd.do_pop) begin
         next_pc = stack_mem[top];
      end else if (cmd.load_low) begin
         next_pc = {pc_high_latch, cmd.low_value};
      end else begin
         case (cmd.pc_op)
            PC_INC: next_pc = pc + PC_W'(1);
            PC_LOAD: next_pc = cmd.load_value;
            PC_HOLD: next_pc = pc;
            default: next_pc = pc;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pc <= PC_RESET;
      end else begin
         pc <= next_pc;
      end
   end

   // only the sequencer write changes the latch
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pc_high_latch <= PCH_RESET;
      end else if (pc_high_latch_we) begin
         pc_high_latch <= pc_high_latch_in;
      end
   end

   // --------------------------------------------------------------
   // indirect data path
   // --------------------------------------------------------------
   indirect_addr u_indirect (
      .sys_clk(sys_clk),
      .reset(reset),
      .req(req),
      .indirect_pointer(indirect_pointer),
      .indirect_bank_select(status_reg[STATUS_BANK_BIT]),
      .bank_direct(status_reg),
      .mem(mem),
      .null_read(null_read)
   );

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         read_data <= INDIRECT_NULL_READ;
      end else begin
         read_data <= null_read ? INDIRECT_NULL_READ : mem_rdata;
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   a_push_then_pop: assert property (@(posedge sys_clk) disable iff (reset)
      cmd.do_push && !cmd.do_pop ##1 cmd.do_pop && !cmd.do_push |=> pc == $past(pc, 2))
      else $error("pop did not return pushed pc");
   a_latch_kept: assert property (@(posedge sys_clk) disable iff (reset)
      (cmd.do_push || cmd.do_pop) && !pc_high_latch_we |=> $stable(pc_high_latch))
      else $error("stack operation changed pc_high_latch");
   a_pointer_wraps: assert property (@(posedge sys_clk) disable iff (reset)
      cmd.do_push && sp == 3'h7 |=> sp == PTR_RESET)
      else $error("stack pointer did not wrap");
   a_pop_steps: assert property (@(posedge sys_clk) disable iff (reset)
      cmd.do_pop && !cmd.do_push |=> sp == $past(sp) - PTR_STEP)
      else $error("pop did not step pointer down");
   a_null_read: assert property (@(posedge sys_clk) disable iff (reset)
      null_read |=> read_data == INDIRECT_NULL_READ)
      else $error("self-referencing read not zero");
   a_low_load: assert property (@(posedge sys_clk) disable iff (reset)
      cmd.load_low && !cmd.do_pop |=> pc == {$past(pc_high_latch), $past(cmd.low_value)})
      else $error("pc low write mis-formed");
   a_reset_pc: assert property (@(posedge sys_clk) reset |=> pc == PC_RESET && sp == PTR_RESET)
      else $error("reset did not clear pc");
   a_redirect: assert property (@(posedge sys_clk) disable iff (reset)
      req.valid && req.file_addr == INDIRECT_PORT_ADDR && indirect_pointer != INDIRECT_PORT_ADDR
      |=> mem.valid && mem.addr[DATA_W-1:0] == $past(indirect_pointer))
      else $error("indirect access not redirected");

   c_wrap: cover property (@(posedge sys_clk) cmd.do_push && sp == 3'h7);
   c_call_return: cover property (@(posedge sys_clk) cmd.do_push ##1 cmd.do_pop);
   c_underflow: cover property (@(posedge sys_clk) cmd.do_pop && sp == PTR_RESET);
endmodule : core_return_stack
`default_nettype wire

// ==== test/seq_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module seq_mem_model (
   // clock
   input wire logic sys_clk,
   // memory side
   input wire core_stack_pkg::mem_req_t mem,
   output logic [core_stack_pkg::DATA_W-1:0] mem_rdata
);
   import core_stack_pkg::*;
   logic [DATA_W-1:0] ram [0:(1<<DADDR_W)-1];
   int writes = 0;
   initial begin
      for (int i = 0; i < (1<<DADDR_W); i++) begin
         ram[i] = 8'(i);
      end
   end
   // unselected: inverted value, never a clean copy
   assign mem_rdata = mem.valid ? ram[mem.addr] : ~ram[mem.addr];
   always @(posedge sys_clk) begin
      if (mem.valid && mem.write) begin
         ram[mem.addr] <= mem.wdata;
         writes <= writes + 1;
      end
   end
endmodule : seq_mem_model
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
   import core_stack_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   seq_cmd_t cmd = '0;
   logic [PCH_W-1:0] pch_in = '0;
   logic pch_we = 1'b0;
   data_req_t req = '0;
   logic [DATA_W-1:0] ptr = '0;
   logic [DATA_W-1:0] status = '0;
   logic [DATA_W-1:0] mem_rdata;
   logic [PC_W-1:0] pc;
   logic [PCH_W-1:0] pch;
   mem_req_t mem;
   logic [DATA_W-1:0] read_data;
   int mismatches = 0;
   int cmp_count = 0;
   int wr0;
   always #20 sys_clk = ~sys_clk;
   core_return_stack i_core_return_stack (.sys_clk(sys_clk), .reset(reset), .cmd(cmd),
      .pc_high_latch_in(pch_in), .pc_high_latch_we(pch_we), .req(req), .indirect_pointer(ptr),
      .status_reg(status), .mem_rdata(mem_rdata), .pc(pc), .pc_high_latch(pch), .mem(mem),
      .read_data(read_data));
   seq_mem_model i_seq_mem_model (.sys_clk(sys_clk), .mem(mem), .mem_rdata(mem_rdata));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic step();
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : step
   task automatic access(input logic wr, input logic [7:0] fa, input logic [7:0] wd);
      req = '{valid: 1'b1, write: wr, file_addr: fa, wdata: wd};
      step();
      req = '0;
   endtask : access
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic test_low_byte();
      pch_in = 5'h15;
      pch_we = 1'b1;
      step();
      pch_we = 1'b0;
      cmd.load_low = 1'b1;
      cmd.low_value = 8'h3C;
      step();
      cmd = '0;
      check("pc", 16'h153C, 16'(pc));
   endtask : test_low_byte
   task automatic test_stack_wrap();
      cmd.pc_op = PC_LOAD;
      for (int k = 0; k <= 10; k++) begin
         cmd.do_push = (k > 0);
         cmd.load_value = 13'h0100 + 13'(k);
         step();
      end
      cmd = '0;
      cmd.do_pop = 1'b1;
      // ten pushes, nine pops: last pop wraps past empty
      for (int j = 0; j < 9; j++) begin
         step();
         check("pc pop", 16'h0100 + 16'((j < 8) ? 9 - j : 9), 16'(pc));
      end
      cmd = '0;
      check("latch", 16'h0015, 16'(pch));
   endtask : test_stack_wrap
   task automatic test_indirect();
      status = 8'h80;
      ptr = 8'h25;
      access(1'b1, 8'h00, 8'h5A);
      check("wr addr", 16'h0325, {6'h00, mem.valid, mem.addr});
      access(1'b0, 8'h00, 8'h00);
      step();
      check("rd data", 16'h005A, 16'(read_data));
      status = 8'h01;
      access(1'b0, 8'h30, 8'h00);
      check("direct", 16'h0330, {6'h00, mem.valid, mem.addr});
      status = 8'h00;
      access(1'b0, 8'h00, 8'h00);
      check("bank0", 16'h0225, {6'h00, mem.valid, mem.addr});
   endtask : test_indirect
   task automatic test_self_ref();
      status = 8'h80;
      ptr = 8'h00;
      wr0 = i_seq_mem_model.writes;
      access(1'b1, 8'h00, 8'hFF);
      check("self wr valid", 16'h0000, 16'(mem.valid));
      step();
      check("writes", 16'(wr0), 16'(i_seq_mem_model.writes));
      access(1'b0, 8'h00, 8'h00);
      step();
      check("self rd", 16'h0000, 16'(read_data));
   endtask : test_self_ref
   initial begin
      repeat (8) @(negedge sys_clk);
      reset = 1'b0;
      check("pc reset", 16'h0000, 16'(pc));
      test_low_byte();
      test_stack_wrap();
      test_indirect();
      test_self_ref();
      summarize();
   end
   initial begin
      #200000;
      mismatches++;
      summarize();
   end
endmodule : tb
`default_nettype wire
